// file: src/sarc_pkg.sv
// constants and types shared by the converter control block
package sarc_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int RESET_TIME_NS = 1000;
    localparam int RESET_CYC = (RESET_TIME_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
    localparam int LSB_EXTRA_NS = 100;
    localparam int LSB_EXTRA_CYC = (LSB_EXTRA_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int RESET_MAX_NS = 1500;
    localparam int RESET_MAX_CYC = RESET_MAX_NS / CLK_PERIOD_NS;
    localparam int BIT_TIME_NS = 2500;
    localparam int BIT_CYC = BIT_TIME_NS / CLK_PERIOD_NS;
    localparam int CONV_MIN_NS = 10000;
    localparam int CONV_MAX_NS = 30000;
    localparam int CONV_MIN_CYC = (CONV_MIN_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
    localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // widths and reset values
    // ----------------------------------------------------------------
    localparam int DATA_WIDTH = 8;
    localparam int CNT_WIDTH = 8;
    localparam logic [DATA_WIDTH-1:0] APPROX_RST = 8'h00;
    localparam logic DONE_N_RST = 1'b0;

    typedef enum logic [1:0] {
        SARC_IDLE  = 2'b00,
        SARC_CLEAR = 2'b01,
        SARC_ARMED = 2'b10,
        SARC_CONV  = 2'b11
    } sarc_state_t;

endpackage : sarc_pkg

// file: src/sarc_sar_if.sv
// carrier between the sequencer and the approximation register
`timescale 1ns/100ps
`default_nettype none
interface sarc_sar_if #(
    parameter int W = 8
);
    logic clear;
    logic set_trial;
    logic decide;
    logic comp_low;
    logic [$clog2(W)-1:0] bit_idx;
    logic [W-1:0] value;

    modport ctrl (
        output clear, set_trial, decide, comp_low, bit_idx,
        input value
    );
    modport regs (
        input clear, set_trial, decide, comp_low, bit_idx,
        output value
    );
endinterface : sarc_sar_if
`default_nettype wire

// file: src/sarc_approx_reg.sv
// successive approximation register with trial and decide steps
`timescale 1ns/100ps
`default_nettype none
module sarc_approx_reg
    import sarc_pkg::*;
#(
    parameter int W = DATA_WIDTH
)(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    sarc_sar_if.regs sar
);
    logic [W-1:0] value_q;
    logic [W-1:0] value_d;

    always_comb
    begin
        value_d = value_q;
        if (sar.clear)
        begin
            value_d = APPROX_RST;
        end
        else if (sar.set_trial)
        begin
            value_d[sar.bit_idx] = 1'b1;
        end
        else if (sar.decide && sar.comp_low)
        begin
            // input below the trial level: drop the trial bit
            value_d[sar.bit_idx] = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            value_q <= APPROX_RST;
        end
        else if (clk_en_in)
        begin
            value_q <= value_d;
        end
    end

    assign sar.value = value_q;

endmodule : sarc_approx_reg
`default_nettype wire

// file: src/sarc_top.sv
// convert and read control of an 8-bit successive approximation converter
`timescale 1ns/100ps
`default_nettype none
// Function
// [RULE_01] Host convert pulse is high for at least 500 ns.
// [RULE_02] Convert rising resets sequencing, clears result, sets done high.
// [RULE_03] Approximation begins on the falling edge of convert.
// [RULE_04] Done flag falls at the end; conversion takes 10 to 30 us.
// [RULE_05] Done flag rises within 1.5 us of convert rising.
// [RULE_06] Reset delay grows slightly when the previous result LSB was one.
// [RULE_07] Host keeps output enable high while a conversion runs.
// [RULE_08] Output enable low during conversion shows the partial value.
// [RULE_09] Data outputs drive only while output enable is low, else float.
// [RULE_10] Host decodes one address; any write to it starts a conversion. The host model drops a write while done is high or a read is on.
// [RULE_11] Host read of that address enables the result onto the bus.
// [RULE_12] Without done polling host waits 30 us before reading.
// [RULE_13] Host may poll done or use its falling edge as interrupt.
// [RULE_14] Host gates decode with write for convert, with read for enable.
// [RULE_15] Host stretches short writes in a flip-flop cleared by done rising.
// [RULE_16] Converter typically accepts convert pulses as short as 300 ns.
// [RULE_17] With a sample-hold, wait 10 us after done falls before converting.
// [RULE_18] Host raises output enable before the next convert pulse.
// [RULE_19] Host never issues convert while the done flag is high.
module sarc_top
    import sarc_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic clk_en_in,
    input wire logic convert_in,
    input wire logic output_enable_n_in,
    input wire logic comparator_in,
    output logic conversion_done_n_out,
    output logic [DATA_WIDTH-1:0] data_out,
    output logic [DATA_WIDTH-1:0] data_oe_out,
    output logic [DATA_WIDTH-1:0] dac_code_out
);
    // ----------------------------------------------------------------
    // reset release and pin synchronisers
    // ----------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_q;
    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic cvt_prev_q;

    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // bit 0 convert, bit 1 output enable (low active), bit 2 comparator
    always_ff @(posedge clk_sys_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            meta_q <= 3'h2;
            sync_q <= 3'h2;
            cvt_prev_q <= 1'b0;
        end
        else if (clk_en_in)
        begin
            meta_q <= {comparator_in, output_enable_n_in, convert_in};
            sync_q <= meta_q;
            cvt_prev_q <= sync_q[0];
        end
    end

    logic cvt_s;
    logic oe_n_s;
    logic cvt_rise;

    assign cvt_s = sync_q[0];
    assign oe_n_s = sync_q[1];
    assign cvt_rise = cvt_s && !cvt_prev_q;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    sarc_sar_if #(.W(DATA_WIDTH)) sar ();

    sarc_approx_reg #(.W(DATA_WIDTH)) u_approx (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_q),
        .clk_en_in(clk_en_in),
        .sar(sar)
    );

    sarc_state_t state_q;
    sarc_state_t state_d;
    logic [CNT_WIDTH-1:0] cnt_q;
    logic [CNT_WIDTH-1:0] cnt_d;
    logic [2:0] bit_q;
    logic [2:0] bit_d;
    logic done_n_q;
    logic done_n_d;

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        bit_d = bit_q;
        done_n_d = done_n_q;
        sar.clear = 1'b0;
        sar.set_trial = 1'b0;
        sar.decide = 1'b0;
        if (cvt_rise)
        begin
            // a new rising edge restarts whatever is in progress
            state_d = SARC_CLEAR; // [RULE_02]
            sar.clear = 1'b1; // [RULE_02]
            cnt_d = CNT_WIDTH'(RESET_CYC - 1);
            if (sar.value[0])
            begin
                cnt_d = CNT_WIDTH'(RESET_CYC + LSB_EXTRA_CYC - 1); // [RULE_06]
            end
        end
        else
        begin
            unique case (state_q)
                SARC_IDLE:
                begin
                    state_d = SARC_IDLE;
                end
                SARC_CLEAR:
                begin
                    if (cnt_q == '0)
                    begin
                        done_n_d = 1'b1; // [RULE_05]
                        state_d = SARC_ARMED;
                    end
                    else
                    begin
                        cnt_d = cnt_q - 1'b1;
                    end
                end
                SARC_ARMED:
                begin
                    // low here means convert already fell: a pulse shorter
                    // than the reset time still starts a conversion
                    if (!cvt_s)
                    begin
                        state_d = SARC_CONV; // [RULE_03] [RULE_16]
                        bit_d = 3'(DATA_WIDTH - 1);
                        cnt_d = CNT_WIDTH'(BIT_CYC - 1);
                    end
                end
                SARC_CONV:
                begin
                    sar.set_trial = (cnt_q == CNT_WIDTH'(BIT_CYC - 1));
                    if (cnt_q == '0)
                    begin
                        sar.decide = 1'b1;
                        cnt_d = CNT_WIDTH'(BIT_CYC - 1);
                        if (bit_q == 3'h0)
                        begin
                            done_n_d = 1'b0; // [RULE_04]
                            state_d = SARC_IDLE;
                        end
                        else
                        begin
                            bit_d = bit_q - 1'b1;
                        end
                    end
                    else
                    begin
                        cnt_d = cnt_q - 1'b1;
                    end
                end
            endcase
        end
    end

    assign sar.bit_idx = bit_q;
    assign sar.comp_low = !sync_q[2];

    always_ff @(posedge clk_sys_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            state_q <= SARC_IDLE;
            cnt_q <= '0;
            bit_q <= 3'h0;
            done_n_q <= DONE_N_RST;
        end
        else if (clk_en_in)
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            bit_q <= bit_d;
            done_n_q <= done_n_d;
        end
    end

    // ----------------------------------------------------------------
    // three-state data outputs
    // ----------------------------------------------------------------
    logic [DATA_WIDTH-1:0] data_d;
    logic [DATA_WIDTH-1:0] oe_d;

    always_comb
    begin
        // the live register is shown, so a read mid-conversion sees
        // the partial value and may fight other drivers
        data_d = sar.value; // [RULE_08]
        oe_d = oe_n_s ? '0 : '1; // [RULE_09]
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            data_out <= APPROX_RST;
            data_oe_out <= '0;
            dac_code_out <= APPROX_RST;
            conversion_done_n_out <= DONE_N_RST;
        end
        else if (clk_en_in)
        begin
            data_out <= data_d;
            data_oe_out <= oe_d;
            dac_code_out <= data_d;
            conversion_done_n_out <= done_n_d;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    localparam int RST_LIM = RESET_MAX_CYC - 3;
    logic [CNT_WIDTH-1:0] clr_cyc_q;
    logic [10:0] conv_cyc_q;
    logic rst_lsb_q;

    always_ff @(posedge clk_sys_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            clr_cyc_q <= '0;
            conv_cyc_q <= '0;
            rst_lsb_q <= 1'b0;
        end
        else if (clk_en_in)
        begin
            clr_cyc_q <= cvt_rise ? '0 : clr_cyc_q + 1'b1;
            conv_cyc_q <= (state_q == SARC_CONV) ? conv_cyc_q + 1'b1 : '0;
            if (cvt_rise)
            begin
                rst_lsb_q <= sar.value[0];
            end
        end
    end

    rise_clears_a: assert property (@(posedge clk_sys_in) // [RULE_02]
        disable iff (!rst_n_q || !clk_en_in)
        cvt_rise |=> state_q == SARC_CLEAR && sar.value == '0)
        else $error("convert rise did not clear the result");
    done_high_a: assert property (@(posedge clk_sys_in) // [RULE_02]
        disable iff (!rst_n_q)
        state_q inside {SARC_ARMED, SARC_CONV} |-> conversion_done_n_out)
        else $error("done flag low while armed or converting");
    armed_hold_a: assert property (@(posedge clk_sys_in) // [RULE_03]
        disable iff (!rst_n_q || !clk_en_in)
        state_q == SARC_ARMED && cvt_s && !cvt_rise |=> state_q == SARC_ARMED)
        else $error("conversion began before convert fell");
    conv_time_a: assert property (@(posedge clk_sys_in) // [RULE_04]
        disable iff (!rst_n_q || !clk_en_in)
        state_q == SARC_CONV && state_d == SARC_IDLE && !cvt_rise
        |-> conv_cyc_q >= 11'(CONV_MIN_CYC - 1)
            && conv_cyc_q == 11'(DATA_WIDTH * BIT_CYC - 1)
            && conv_cyc_q < 11'(CONV_MAX_CYC)
        ##1 !conversion_done_n_out)
        else $error("conversion length out of range");
    reset_bound_a: assert property (@(posedge clk_sys_in) // [RULE_05]
        disable iff (!rst_n_q || !clk_en_in)
        state_q == SARC_CLEAR |-> clr_cyc_q < CNT_WIDTH'(RST_LIM))
        else $error("done flag rise too late");
    lsb_extra_a: assert property (@(posedge clk_sys_in) // [RULE_06]
        disable iff (!rst_n_q || !clk_en_in)
        state_q == SARC_CLEAR && state_d == SARC_ARMED
        |-> clr_cyc_q == CNT_WIDTH'(rst_lsb_q ? RESET_CYC + LSB_EXTRA_CYC - 1
                                              : RESET_CYC - 1))
        else $error("reset delay does not match previous lsb");
    partial_out_a: assert property (@(posedge clk_sys_in) // [RULE_08]
        disable iff (!rst_n_q || !clk_en_in)
        !oe_n_s && state_q == SARC_CONV
        |=> data_oe_out == '1 && data_out == $past(sar.value))
        else $error("partial value not driven while enabled");
    float_a: assert property (@(posedge clk_sys_in) // [RULE_09]
        disable iff (!rst_n_q || !clk_en_in)
        oe_n_s |=> data_oe_out == '0)
        else $error("data driven while output enable high");
    short_pulse_a: assert property (@(posedge clk_sys_in) // [RULE_16]
        disable iff (!rst_n_q || !clk_en_in)
        state_q == SARC_CLEAR && !cvt_s ##1 !cvt_rise
        |-> state_q inside {SARC_CLEAR, SARC_ARMED})
        else $error("short convert pulse lost");

    full_conv_c: cover property (@(posedge clk_sys_in)
        $fell(conversion_done_n_out));
    restart_c: cover property (@(posedge clk_sys_in)
        state_q == SARC_CONV && cvt_rise);
    early_read_c: cover property (@(posedge clk_sys_in)
        state_q == SARC_CONV && !oe_n_s);

endmodule : sarc_top
`default_nettype wire

// file: verification/sarc_host_model.sv
// host bus glue model: address decode and convert pulse stretcher
`timescale 1ns/100ps
`default_nettype none
module sarc_host_model #(
    parameter logic [7:0] ADC_ADDR = 8'h40
)(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] addr_in,
    input wire logic wr_n_in,
    input wire logic rd_n_in,
    input wire logic done_n_in,
    output logic convert_out,
    output logic oe_n_out
);
    logic hit;
    logic done_n_q;
    logic conv_q;
    logic conv_d;

    // write data is never looked at: any write to the address starts unless busy or reading
    assign hit = (addr_in == ADC_ADDR);
    assign oe_n_out = !(hit && !rd_n_in);
    assign convert_out = conv_q;

    always_comb
    begin
        conv_d = conv_q;
        // a write while busy or while reading is dropped
        if (hit && !wr_n_in && !done_n_in && oe_n_out)
        begin
            conv_d = 1'b1;
        end
        if (done_n_in && !done_n_q)
        begin
            conv_d = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            conv_q <= 1'b0;
            done_n_q <= 1'b0;
        end
        else
        begin
            conv_q <= conv_d;
            done_n_q <= done_n_in;
        end
    end
endmodule : sarc_host_model
`default_nettype wire

// file: verification/sarc_top_bench.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none
module sarc_top_bench;
    import sarc_pkg::*;
    localparam logic [7:0] ADC_ADDR = 8'h40;
    logic clk_sys_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic clk_en_in = 1'b1;
    logic comparator_in = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr_n = 1'b1;
    logic rd_n = 1'b1;
    logic hold_conv = 1'b0;
    logic host_conv;
    logic oe_n;
    logic done_n;
    logic [7:0] data;
    logic [7:0] data_oe;
    logic [7:0] dac_code;
    logic [7:0] analog = 8'h00;
    int bad_count = 0;
    int samples_checked = 0;
    int d0;
    int d1;
    int n;

    always #10 clk_sys_in = ~clk_sys_in;

    // ideal analog input: keep the bit while input >= trial code
    always @(negedge clk_sys_in)
        comparator_in <= (analog >= dac_code);

    sarc_host_model #(.ADC_ADDR(ADC_ADDR)) host (
        .clk_in(clk_sys_in), .rst_n_in(arst_n_in), .addr_in(addr),
        .wr_n_in(wr_n), .rd_n_in(rd_n), .done_n_in(done_n),
        .convert_out(host_conv), .oe_n_out(oe_n));

    sarc_top dut (
        .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
        .clk_en_in(clk_en_in), .convert_in(host_conv | hold_conv),
        .output_enable_n_in(oe_n), .comparator_in(comparator_in),
        .conversion_done_n_out(done_n), .data_out(data),
        .data_oe_out(data_oe), .dac_code_out(dac_code));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic wait_done(input logic lvl, input int lim,
                             output int cnt);
        cnt = 0;
        while (done_n !== lvl && cnt < lim)
        begin
            @(negedge clk_sys_in);
            cnt++;
        end
        if (done_n !== lvl)
        begin
            check(1'b0, "done flag wait timed out");
            wrap_up();
        end
    endtask : wait_done

    // one short write strobe; the host glue stretches it
    task automatic bus_write();
        @(negedge clk_sys_in);
        addr = ADC_ADDR;
        wr_n = 1'b0;
        @(negedge clk_sys_in);
        wr_n = 1'b1;
        addr = 8'h00;
    endtask : bus_write

    task automatic bus_read(output logic [7:0] r);
        @(negedge clk_sys_in);
        addr = ADC_ADDR;
        rd_n = 1'b0;
        repeat (4) @(negedge clk_sys_in);
        r = data;
        check(data_oe === 8'hff, "outputs not driven");
        rd_n = 1'b1;
        addr = 8'h00;
        repeat (4) @(negedge clk_sys_in);
        check(data_oe === 8'h00, "outputs not floated");
    endtask : bus_read

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic run_conv(input logic [7:0] a, input bit poll,
                            output int d);
        int c;
        logic [7:0] r;
        analog = a;
        bus_write();
        wait_done(1'b1, 100, d);
        check(d <= RESET_MAX_CYC, "done flag rose late");
        check(d >= 500 / CLK_PERIOD_NS, "convert pulse short");
        check(dac_code === 8'h00, "old result kept");
        if (poll)
        begin
            wait_done(1'b0, CONV_MAX_CYC, c);
            check(c >= CONV_MIN_CYC && c + d <= CONV_MAX_CYC,
                  "conversion time");
        end
        else
        begin
            repeat (CONV_MAX_CYC) @(negedge clk_sys_in);
            check(done_n === 1'b0, "not done after max time");
        end
        bus_read(r);
        check(r === a, "result mismatch");
        repeat (500) @(negedge clk_sys_in);
    endtask : run_conv

    // a 300 ns pulse that falls long before the reset time is over
    task automatic short_pulse();
        int c;
        logic [7:0] r;
        analog = 8'h21;
        @(negedge clk_sys_in);
        hold_conv = 1'b1;
        repeat (300 / CLK_PERIOD_NS) @(negedge clk_sys_in);
        hold_conv = 1'b0;
        wait_done(1'b1, 100, c);
        check(c <= RESET_MAX_CYC, "done flag rose late");
        wait_done(1'b0, CONV_MAX_CYC, c);
        bus_read(r);
        check(r === 8'h21, "short pulse result");
        repeat (500) @(negedge clk_sys_in);
    endtask : short_pulse

    // convert held high well past reset, then a read mid-conversion
    task automatic held_convert();
        int c;
        logic [7:0] r;
        analog = 8'h96;
        @(negedge clk_sys_in);
        hold_conv = 1'b1;
        wait_done(1'b1, 100, c);
        repeat (300) @(negedge clk_sys_in);
        check(done_n === 1'b1 && dac_code === 8'h00,
              "sequence ran before convert fell");
        // clock enable low must hide the convert fall from the sequencer
        clk_en_in = 1'b0;
        hold_conv = 1'b0;
        repeat (50) @(negedge clk_sys_in);
        check(done_n === 1'b1 && dac_code === 8'h00,
              "state moved while clock enable low");
        clk_en_in = 1'b1;
        repeat (200) @(negedge clk_sys_in);
        bus_read(r);
        check(r[7] === 1'b1 && r[3:0] === 4'h0 && done_n === 1'b1,
              "partial value wrong");
        wait_done(1'b0, CONV_MAX_CYC, c);
        bus_read(r);
        check(r === 8'h96, "held result mismatch");
    endtask : held_convert

    initial
    begin
        repeat (20) @(negedge clk_sys_in);
        arst_n_in = 1'b1;
        repeat (4) @(negedge clk_sys_in);
        check(done_n === 1'b0 && data_oe === 8'h00 && data === 8'h00,
              "reset values");
        run_conv(8'h5a, 1'b1, d0);
        run_conv(8'hb7, 1'b0, n);
        check(n == d0, "reset delay after lsb zero");
        run_conv(8'h3c, 1'b1, d1);
        check(d1 == d0 + LSB_EXTRA_CYC, "delay after lsb one");
        short_pulse();
        held_convert();
        wrap_up();
    end
endmodule : sarc_top_bench
`default_nettype wire
